// File: verilog/ifsb_pkg.sv
// Package: register map, flag layouts, bus states and helpers for the interrupt flag bank
package ifsb_pkg;

  localparam int unsigned IFSB_ADDR_W = 12;
  localparam int unsigned IFSB_FLAG_W = 16;

  // Byte offsets of the word registers
  localparam logic [11:0] IFSB_OFF_GROUP_A = 12'h000;
  localparam logic [11:0] IFSB_OFF_GROUP_B = 12'h004;
  localparam logic [11:0] IFSB_OFF_GROUP_C = 12'h008;
  localparam logic [11:0] IFSB_OFF_IRQ_STS = 12'h00C;
  localparam logic [11:0] IFSB_OFF_IRQ_MSK = 12'h010;

  // Implemented flag positions per group; zeros are unimplemented
  localparam logic [15:0] IFSB_IMPL_A = 16'h3FEF;
  localparam logic [15:0] IFSB_IMPL_B = 16'hFEDF;
  localparam logic [15:0] IFSB_IMPL_C = 16'h3FE3;

  localparam logic [15:0] IFSB_RST_FLAGS = 16'h0000;
  localparam logic [2:0] IFSB_RST_IRQ = 3'h0;

  // Summary status bits, one per flag group
  localparam int unsigned IFSB_STS_A = 0;
  localparam int unsigned IFSB_STS_B = 1;
  localparam int unsigned IFSB_STS_C = 2;
  localparam int unsigned IFSB_STS_W = 3;

  // Field order follows vector number, bit 0 upward
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic adc_done_flag;
    logic uart_one_tx_flag;
    logic uart_one_rx_flag;
    logic spi_one_event_flag;
    logic spi_one_fault_flag;
    logic timer_three_flag;
    logic timer_two_flag;
    logic out_cmp_two_flag;
    logic in_cap_two_flag;
    logic rsv_4;
    logic timer_one_flag;
    logic out_cmp_one_flag;
    logic in_cap_one_flag;
    logic ext_irq_zero_flag;
  } ifsb_group_a_t;

  typedef struct packed {
    logic uart_two_tx_flag;
    logic uart_two_rx_flag;
    logic ext_irq_two_flag;
    logic timer_five_flag;
    logic timer_four_flag;
    logic out_cmp_four_flag;
    logic out_cmp_three_flag;
    logic rsv_8;
    logic in_cap_eight_flag;
    logic in_cap_seven_flag;
    logic rsv_5;
    logic ext_irq_one_flag;
    logic pin_change_flag;
    logic comparator_flag;
    logic i2c_one_master_flag;
    logic i2c_one_slave_flag;
  } ifsb_group_b_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic parallel_port_flag;
    logic out_cmp_eight_flag;
    logic out_cmp_seven_flag;
    logic out_cmp_six_flag;
    logic out_cmp_five_flag;
    logic in_cap_six_flag;
    logic in_cap_five_flag;
    logic in_cap_four_flag;
    logic in_cap_three_flag;
    logic [2:0] rsv_lo;
    logic spi_two_event_flag;
    logic spi_two_fault_flag;
  } ifsb_group_c_t;

  typedef enum logic [1:0] {
    IFSB_ST_IDLE = 2'b01,
    IFSB_ST_ACCESS = 2'b10
  } ifsb_apb_st_t;

  // Byte-lane merge of write data into an old word
  function automatic logic [31:0] ifsb_merge(input logic [31:0] old, input logic [31:0] wdata,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address hit test shared by read and write decode
  function automatic logic ifsb_hit(input logic [11:0] addr);
    return (addr == IFSB_OFF_GROUP_A) || (addr == IFSB_OFF_GROUP_B) || (addr == IFSB_OFF_GROUP_C) ||
           (addr == IFSB_OFF_IRQ_STS) || (addr == IFSB_OFF_IRQ_MSK);
  endfunction

endpackage

// File: verilog/ifsb_flag_reg.sv
// One 16-bit sticky flag register with software write and hardware set
`timescale 1ns/1ps
module ifsb_flag_reg
  import ifsb_pkg::*;
#(
  parameter logic [15:0] IMPL = 16'hFFFF,
  parameter logic [15:0] RST = 16'h0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] hw_set,
  output logic [15:0] flags_q,
  output logic set_seen
);

  logic [15:0] flags_d;

  always_comb begin
    flags_d = flags_q;
    if (wr_en) begin
      flags_d = wr_data;
    end
    // Hardware set applied last so it beats a same-cycle clear
    flags_d = (flags_d | hw_set) & IMPL;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= RST & IMPL;
    end else if (ce) begin
      flags_q <= flags_d;
    end
  end

  assign set_seen = |(hw_set & IMPL);

endmodule

// File: verilog/ifsb_apb_slave.sv
// APB slave front end: phase tracking, registered ready, error and read data
`timescale 1ns/1ps
module ifsb_apb_slave
  import ifsb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] rd_word,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wr_stb
);

  ifsb_apb_st_t st_q;
  logic setup;

  assign setup = psel && !penable;
  // Write lands at the single edge where the master sees pready
  assign wr_stb = ce && psel && penable && pwrite && pready && ifsb_hit(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= IFSB_ST_IDLE;
    end else if (ce) begin
      case (st_q)
        IFSB_ST_IDLE: begin
          if (setup) begin
            st_q <= IFSB_ST_ACCESS;
          end
        end
        IFSB_ST_ACCESS: begin
          st_q <= IFSB_ST_IDLE;
        end
        default: begin
          st_q <= IFSB_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup && (st_q == IFSB_ST_IDLE);
      pslverr <= setup && (st_q == IFSB_ST_IDLE) && !ifsb_hit(paddr);
    end
  end

  // Read data captured in setup; it is one cycle old at the sample edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (setup && !pwrite) begin
        prdata <= rd_word;
      end else if (!psel) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// File: verilog/ifsb_top.sv
// Top of the interrupt flag status bank: three flag groups, summary status and mask, APB access
//
// Summary of operation
// - A flag reads 1 once its source has raised a request and 0 while no request has occurred.
// - Every implemented flag in all three groups is software read/write and is 0 after reset.
// - Bits 15 and 14 of group A are unimplemented, read 0 and ignore writes.
// - Group A holds adc done at 13, uart one tx 12, uart one rx 11, spi one event 10, fault 9, timer three 8.
// - Group A holds timer two 7, out cmp two 6, in cap two 5, timer one 3, out cmp one 2, in cap one 1, ext irq zero 0.
// - Group B holds uart two tx 15, rx 14, ext irq two 13, timer five 12, timer four 11, out cmp four 10, three 9.
// - Group B holds in cap eight 7, seven 6, ext irq one 4, pin change 3, comparator 2, i2c master 1, slave 0.
// - Group C holds parallel port 13, out cmp eight to five at 12 to 9 and in cap six at 8; 15 and 14 read 0.
// - Group C holds in cap five, four, three at 7 to 5, zeros at 4 to 2, spi two event 1 and fault 0.
// - Flags are placed in vector-number order, ext irq zero at bit 0 of group A.
`timescale 1ns/1ps
module ifsb_top
  import ifsb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ifsb_group_a_t evt_a,
  input wire ifsb_group_b_t evt_b,
  input wire ifsb_group_c_t evt_c,
  output ifsb_group_a_t flags_a,
  output ifsb_group_b_t flags_b,
  output ifsb_group_c_t flags_c,
  output logic irq
);

  logic wr_stb;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic wr_sts;
  logic wr_msk;
  logic [31:0] rd_word;
  logic [31:0] old_word;
  logic [31:0] new_word;
  logic [15:0] flags_a_raw;
  logic [15:0] flags_b_raw;
  logic [15:0] flags_c_raw;
  logic set_a;
  logic set_b;
  logic set_c;
  logic [2:0] sts_q;
  logic [2:0] sts_d;
  logic [2:0] msk_q;
  logic [2:0] evt_sum;
  // Position-filtered requests and write data per group
  ifsb_group_a_t req_a;
  ifsb_group_b_t req_b;
  ifsb_group_c_t req_c;
  ifsb_group_a_t wdat_a;
  ifsb_group_b_t wdat_b;
  ifsb_group_c_t wdat_c;

  // Copies documented positions only, so a stray drive on a reserved bit never reaches a flop
  function automatic ifsb_group_a_t ifsb_pick_a(input logic [15:0] raw);
    ifsb_group_a_t src;
    ifsb_group_a_t v;
    src = raw;
    v = 16'h0000;
    v.adc_done_flag = src.adc_done_flag;
    v.uart_one_tx_flag = src.uart_one_tx_flag;
    v.uart_one_rx_flag = src.uart_one_rx_flag;
    v.spi_one_event_flag = src.spi_one_event_flag;
    v.spi_one_fault_flag = src.spi_one_fault_flag;
    v.timer_three_flag = src.timer_three_flag;

    v.timer_two_flag = src.timer_two_flag;
    v.out_cmp_two_flag = src.out_cmp_two_flag;
    v.in_cap_two_flag = src.in_cap_two_flag;
    v.timer_one_flag = src.timer_one_flag;
    v.out_cmp_one_flag = src.out_cmp_one_flag;
    v.in_cap_one_flag = src.in_cap_one_flag;
    v.ext_irq_zero_flag = src.ext_irq_zero_flag;
    return v;
  endfunction

  // Bits 8 and 5 of group B stay zero
  function automatic ifsb_group_b_t ifsb_pick_b(input logic [15:0] raw);
    ifsb_group_b_t src;
    ifsb_group_b_t v;
    src = raw;
    v = 16'h0000;
    v.uart_two_tx_flag = src.uart_two_tx_flag;
    v.uart_two_rx_flag = src.uart_two_rx_flag;
    v.ext_irq_two_flag = src.ext_irq_two_flag;
    v.timer_five_flag = src.timer_five_flag;
    v.timer_four_flag = src.timer_four_flag;
    v.out_cmp_four_flag = src.out_cmp_four_flag;
    v.out_cmp_three_flag = src.out_cmp_three_flag;

    v.in_cap_eight_flag = src.in_cap_eight_flag;
    v.in_cap_seven_flag = src.in_cap_seven_flag;
    v.ext_irq_one_flag = src.ext_irq_one_flag;
    v.pin_change_flag = src.pin_change_flag;
    v.comparator_flag = src.comparator_flag;
    v.i2c_one_master_flag = src.i2c_one_master_flag;
    v.i2c_one_slave_flag = src.i2c_one_slave_flag;
    return v;
  endfunction

  // Bits 15, 14 and 4 to 2 of group C stay zero
  function automatic ifsb_group_c_t ifsb_pick_c(input logic [15:0] raw);
    ifsb_group_c_t src;
    ifsb_group_c_t v;
    src = raw;
    v = 16'h0000;
    v.parallel_port_flag = src.parallel_port_flag;
    v.out_cmp_eight_flag = src.out_cmp_eight_flag;
    v.out_cmp_seven_flag = src.out_cmp_seven_flag;
    v.out_cmp_six_flag = src.out_cmp_six_flag;
    v.out_cmp_five_flag = src.out_cmp_five_flag;
    v.in_cap_six_flag = src.in_cap_six_flag;

    v.in_cap_five_flag = src.in_cap_five_flag;
    v.in_cap_four_flag = src.in_cap_four_flag;
    v.in_cap_three_flag = src.in_cap_three_flag;
    v.spi_two_event_flag = src.spi_two_event_flag;
    v.spi_two_fault_flag = src.spi_two_fault_flag;
    return v;
  endfunction

  // Summary status and mask share one read layout
  function automatic logic [31:0] ifsb_irq_word(input logic [2:0] val);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[IFSB_STS_W-1:0] = val;
    return w;
  endfunction

  ifsb_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .rd_word(rd_word),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb)
  );

  // Write decode
  always_comb begin
    wr_a = 1'b0;
    wr_b = 1'b0;
    wr_c = 1'b0;
    wr_sts = 1'b0;
    wr_msk = 1'b0;
    if (!wr_stb) begin
      wr_a = 1'b0;
    end else if (paddr == IFSB_OFF_GROUP_A) begin
      wr_a = 1'b1;
    end else if (paddr == IFSB_OFF_GROUP_B) begin
      wr_b = 1'b1;
    end else if (paddr == IFSB_OFF_GROUP_C) begin
      wr_c = 1'b1;
    end else if (paddr == IFSB_OFF_IRQ_STS) begin
      wr_sts = 1'b1;
    end else if (paddr == IFSB_OFF_IRQ_MSK) begin
      wr_msk = 1'b1;
    end
  end

  // Read decode; unimplemented and upper bits come back as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (paddr == IFSB_OFF_GROUP_A) begin
      rd_word = {16'h0000, flags_a_raw};
    end else if (paddr == IFSB_OFF_GROUP_B) begin
      rd_word = {16'h0000, flags_b_raw};
    end else if (paddr == IFSB_OFF_GROUP_C) begin
      rd_word = {16'h0000, flags_c_raw};
    end else if (paddr == IFSB_OFF_IRQ_STS) begin
      rd_word = ifsb_irq_word(sts_q);
    end else if (paddr == IFSB_OFF_IRQ_MSK) begin
      rd_word = ifsb_irq_word(msk_q);
    end
  end

  // Byte lanes not strobed keep the register's present contents, except at the status register, whose set bits they clear
  always_comb begin
    old_word = rd_word;
    new_word = ifsb_merge(old_word, pwdata, pstrb);
  end

  // Requests and write data pass the same position filter
  always_comb begin
    req_a = ifsb_pick_a(evt_a);
    req_b = ifsb_pick_b(evt_b);
    req_c = ifsb_pick_c(evt_c);
    wdat_a = ifsb_pick_a(new_word[15:0]);
    wdat_b = ifsb_pick_b(new_word[15:0]);
    wdat_c = ifsb_pick_c(new_word[15:0]);
  end

  // Hardware set is applied after the write inside each group, so set wins
  ifsb_flag_reg #(
    .IMPL(IFSB_IMPL_A),
    .RST(IFSB_RST_FLAGS)
  ) u_group_a (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_en(wr_a),
    .wr_data(wdat_a),
    .hw_set(req_a),
    .flags_q(flags_a_raw),
    .set_seen(set_a)
  );

  ifsb_flag_reg #(
    .IMPL(IFSB_IMPL_B),
    .RST(IFSB_RST_FLAGS)
  ) u_group_b (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_en(wr_b),
    .wr_data(wdat_b),
    .hw_set(req_b),
    .flags_q(flags_b_raw),
    .set_seen(set_b)
  );

  ifsb_flag_reg #(
    .IMPL(IFSB_IMPL_C),
    .RST(IFSB_RST_FLAGS)
  ) u_group_c (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_en(wr_c),
    .wr_data(wdat_c),
    .hw_set(req_c),
    .flags_q(flags_c_raw),
    .set_seen(set_c)
  );

  // Flag outputs feed enable and priority logic straight from the flops
  assign flags_a = flags_a_raw;
  assign flags_b = flags_b_raw;
  assign flags_c = flags_c_raw;

  // Summary status: a group bit latches on any hardware set in that group
  always_comb begin
    evt_sum = 3'h0;
    evt_sum[IFSB_STS_A] = set_a;
    evt_sum[IFSB_STS_B] = set_b;
    evt_sum[IFSB_STS_C] = set_c;
    sts_d = sts_q;
    if (wr_sts) begin
      sts_d = sts_q & ~new_word[IFSB_STS_W-1:0];
    end
    // New event beats a write-one clear in the same cycle
    sts_d = sts_d | evt_sum;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= IFSB_RST_IRQ;
    end else if (ce) begin
      sts_q <= sts_d;
    end
  end

  // Mask only gates the interrupt line; the flags themselves are never masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msk_q <= IFSB_RST_IRQ;
    end else if (ce && wr_msk) begin
      msk_q <= new_word[IFSB_STS_W-1:0];
    end
  end

  // Registered output, so it trails the status bit by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(sts_q & msk_q);
    end
  end

endmodule

// File: testbench/ifsb_monitor.sv
// Port-level assertions for the interrupt flag bank
`timescale 1ns/1ps
module ifsb_monitor
  import ifsb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire ifsb_group_a_t evt_a,
  input wire ifsb_group_b_t evt_b,
  input wire ifsb_group_c_t evt_c,
  input wire ifsb_group_a_t flags_a,
  input wire ifsb_group_b_t flags_b,
  input wire ifsb_group_c_t flags_c
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rsv_a_zero: assert property ((flags_a & ~IFSB_IMPL_A) == 16'h0000)
    else $error("group a reserved bit set");
  a_rsv_b_zero: assert property ((flags_b & ~IFSB_IMPL_B) == 16'h0000)
    else $error("group b reserved bit set");
  a_rsv_c_zero: assert property ((flags_c & ~IFSB_IMPL_C) == 16'h0000)
    else $error("group c reserved bit set");
  a_evt_sets_a: assert property (ce && evt_a != 16'h0000 |=>
    (flags_a & $past(evt_a)) == ($past(evt_a) & IFSB_IMPL_A)) else $error("group a event lost");
  a_evt_sets_b: assert property (ce && evt_b != 16'h0000 |=>
    (flags_b & $past(evt_b)) == ($past(evt_b) & IFSB_IMPL_B)) else $error("group b event lost");
  a_evt_sets_c: assert property (ce && evt_c != 16'h0000 |=>
    (flags_c & $past(evt_c)) == ($past(evt_c) & IFSB_IMPL_C)) else $error("group c event lost");
  a_sticky_a: assert property (!(ce && psel && penable && pwrite && pready && paddr == IFSB_OFF_GROUP_A) |=>
    ($past(flags_a) & ~flags_a) == 16'h0000) else $error("group a flag fell without write");
  a_ce_freeze: assert property (!ce |=> $stable(flags_a) && $stable(flags_b) && $stable(flags_c))
    else $error("flags moved with clock enable low");
  c_evt_a: cover property (ce && evt_a != 16'h0000);
  c_wr_a: cover property (psel && penable && pwrite && pready && paddr == IFSB_OFF_GROUP_A);
  c_ce_low: cover property (!ce && evt_b != 16'h0000);
endmodule

bind ifsb_top ifsb_monitor i_ifsb_monitor (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .evt_a(evt_a), .evt_b(evt_b),
  .evt_c(evt_c), .flags_a(flags_a), .flags_b(flags_b), .flags_c(flags_c));

// File: testbench/ifsb_evt_src.sv
// Peripheral event sources driving request patterns into the flag bank
`timescale 1ns/1ps
module ifsb_evt_src
  import ifsb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [15:0] pat_a,
  input wire logic [15:0] pat_b,
  input wire logic [15:0] pat_c,
  output ifsb_group_a_t evt_a,
  output ifsb_group_b_t evt_b,
  output ifsb_group_c_t evt_c
);
  // Requests last exactly as long as en is held, so a one-cycle en gives a pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {evt_c, evt_b, evt_a} <= 48'h0;
    end else begin
      {evt_c, evt_b, evt_a} <= en ? {pat_c, pat_b, pat_a} : 48'h0;
    end
  end
endmodule

// File: testbench/ifsb_top_tb.sv
// Self-checking bench for the interrupt flag bank
`timescale 1ns/1ps
module ifsb_top_tb;
  import ifsb_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, en = 0, pready, pslverr, irq, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic [15:0] pa = 0, pb = 0, pc = 0;
  logic [47:0] fl;
  ifsb_group_a_t evt_a, flags_a;
  ifsb_group_b_t evt_b, flags_b;
  ifsb_group_c_t evt_c, flags_c;
  int miscompares = 0, compares = 0, mdl[3];
  logic [15:0] impl[3] = '{IFSB_IMPL_A, IFSB_IMPL_B, IFSB_IMPL_C};
  assign fl = {flags_c, flags_b, flags_a};
  always #20 pclk = ~pclk;
  ifsb_top i_ifsb_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_a(evt_a), .evt_b(evt_b), .evt_c(evt_c), .flags_a(flags_a), .flags_b(flags_b), .flags_c(flags_c), .irq(irq));
  ifsb_evt_src i_ifsb_evt_src (.pclk(pclk), .presetn(presetn), .en(en), .pat_a(pa), .pat_b(pb), .pat_c(pc),
    .evt_a(evt_a), .evt_b(evt_b), .evt_c(evt_c));
  task automatic give_verdict;
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) chk("pready", 1, 0);
  endtask
  task automatic wr(input int g, input logic [15:0] d, input logic [3:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}};
    apb(1, 12'(4 * g), {16'h0000, d}, s);
    mdl[g] = ((mdl[g] & ~m) | (d & m)) & impl[g];
  endtask
  task automatic rdall;
    for (int g = 0; g < 3; g++) begin
      apb(0, 12'(4 * g), 0, 0);
      chk("group read", mdl[g], rd);
      chk("flag port", mdl[g], {16'h0000, fl[g*16 +: 16]});
    end
  endtask
  task automatic fire(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    {pa, pb, pc, en} <= {a, b, c, 1'b1};
    @(posedge pclk);
    en <= 0;
    idle(2);
    mdl[0] |= a & impl[0];
    mdl[1] |= b & impl[1];
    mdl[2] |= c & impl[2];
  endtask
  initial begin
    void'($urandom(32'h589a3531));
    idle(2);
    presetn <= 1;
    for (int i = 0; i < 6; i++) begin
      apb(0, 12'(4 * i), 0, 0);
      chk("reset read", 0, rd);
      chk("slave error", i == 5, err);
    end
    apb(1, 12'h014, 32'h0000_FFFF, 4'hF);
    chk("write error", 1, err);
    apb(1, IFSB_OFF_IRQ_MSK, 32'h7, 4'hF);
    apb(0, IFSB_OFF_IRQ_MSK, 0, 0);
    chk("mask read", 32'h7, rd);
    fire(16'h0001, 0, 0);
    idle(1);
    chk("irq set", 1, irq);
    apb(0, IFSB_OFF_IRQ_STS, 0, 0);
    chk("irq status", 32'h1, rd);
    apb(1, IFSB_OFF_IRQ_MSK, 0, 4'hF);
    idle(2);
    chk("irq masked", 0, irq);
    apb(1, IFSB_OFF_IRQ_MSK, 32'h7, 4'hF);
    apb(1, IFSB_OFF_IRQ_STS, 32'h1, 4'hF);
    idle(2);
    chk("irq cleared", 0, irq);
    apb(0, IFSB_OFF_IRQ_STS, 0, 0);
    chk("status cleared", 0, rd);
    for (int g = 0; g < 3; g++) begin
      wr(g, 16'hFFFF, 4'hF);
      rdall;
      wr(g, 16'h0000, 4'hF);
    end
    wr(1, 16'hFFFF, 4'b0001);
    rdall;
    wr(1, 16'h0000, 4'hF);
    for (int g = 0; g < 3; g++) begin
      for (int b = 0; b < 16; b++) begin
        fire(g == 0 ? 16'(1 << b) : 0, g == 1 ? 16'(1 << b) : 0, g == 2 ? 16'(1 << b) : 0);
        rdall;
        wr(g, 16'h0000, 4'hF);
      end
    end
    repeat (20) begin
      fire(16'($urandom), 16'($urandom), 16'($urandom));
      rdall;
    end
    presetn <= 0;
    idle(2);
    presetn <= 1;
    mdl = '{0, 0, 0};
    rdall;
    {pa, pb, pc, en} <= {48'hFFFF_FFFF_FFFF, 1'b1};
    for (int g = 0; g < 3; g++) wr(g, 16'h0000, 4'hF);
    en <= 0;
    idle(2);
    mdl = '{impl[0], impl[1], impl[2]};
    rdall;
    for (int g = 0; g < 3; g++) wr(g, 16'h0000, 4'hF);
    ce <= 0;
    en <= 1;
    idle(2);
    en <= 0;
    idle(2);
    ce <= 1;
    rdall;
    give_verdict;
  end
  initial begin
    idle(30000);
    miscompares++;
    give_verdict;
  end
endmodule
